// file: verilog/fcs_defines.vh
// Constants for the configuration sequencer: states, timings and pin codes.
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// Clock period in picoseconds (200 MHz core clock).
`define FCS_CLK_PERIOD_PS 5000
// Power-on reset duration in milliseconds.
`define FCS_POR_TIME_MS 100
// Power-on reset duration in clock cycles: 100 ms of 5 ns cycles, sized to the counter.
`define FCS_POR_CYCLES 25'h1312d00
// Width of the power-on counter.
`define FCS_POR_W 25
// Last stage-counter value of the reset stage before configuration; the stage lasts nine cycles.
`define FCS_RST_STAGE_CYCLES 8'h08
// Last stage-counter value of the initialization stage; the stage lasts seventeen cycles.
`define FCS_INIT_CYCLES 8'h10
// Stage-counter cycles before a low status is believed in the configuration stage.
`define FCS_STATUS_SETTLE 8'h03
// Width of the stage counter.
`define FCS_STAGE_W 8

// Sequencer state codes.
`define FCS_ST_POR 3'h0
`define FCS_ST_WAIT 3'h1
`define FCS_ST_RESET 3'h2
`define FCS_ST_CONFIG 3'h3
`define FCS_ST_INIT 3'h4
`define FCS_ST_USER 3'h5
`define FCS_ST_W 3

// Scheme select codes.
`define FCS_SCHEME_ACTIVE 2'h0
`define FCS_SCHEME_PASSIVE 2'h1

`endif

// file: verilog/fcs_config_sequencer.v
// Power-up and configuration sequencer of the programmable logic device.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

module fcs_config_sequencer #(
    parameter [`FCS_POR_W-1:0] POR_CYCLES = `FCS_POR_CYCLES
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_config_status_n,
    input wire i_config_complete_flag,
    input wire i_chain_enable_in_n,
    input wire i_reconfig_request_n,
    input wire [1:0] i_scheme_select,
    input wire i_serial_memory_data_in,
    input wire i_scan_config_done,
    input wire i_config_data_done,
    input wire i_config_error,
    output reg o_config_status_n_out,
    output reg o_config_status_n_oe_n,
    output reg o_config_complete_flag_out,
    output reg o_config_complete_flag_oe_n,
    output reg o_chain_enable_out_n,
    output reg o_serial_command_out,
    output reg o_serial_load_enable,
    output reg o_serial_data_bit,
    output reg o_user_io_oe_n,
    output reg o_user_io_pullup_en,
    output reg o_user_mode,
    output reg o_stage_reset,
    output reg o_stage_config,
    output reg o_stage_init
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    // Two flops per pin; only the second stage is read by logic.
    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    wire [5:0] pins_in = {i_config_status_n, i_config_complete_flag, i_chain_enable_in_n,
                          i_reconfig_request_n, i_serial_memory_data_in, i_scan_config_done};

    // Capture pins into the two-stage synchroniser.
    // Reset loads the idle high level, so no false low follows reset.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            sync1_q <= 6'h3f;
            sync2_q <= 6'h3f;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
        end
    end

    // Synchronised views of the pins.
    wire status_s = sync2_q[5];
    wire done_s = sync2_q[4];
    wire ce_n_s = sync2_q[3];
    wire reconf_n_s = sync2_q[2];
    wire mem_data_s = sync2_q[1];
    wire scan_done_s = sync2_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    reg [`FCS_ST_W-1:0] state_q;
    reg [`FCS_ST_W-1:0] state_d;
    reg [`FCS_POR_W-1:0] por_cnt_q;
    reg [`FCS_STAGE_W-1:0] stage_cnt_q;
    // Set once a scan configuration is accepted; held until a restart.
    reg scan_cfg_q;
    // The scheme select is a static strap, read without synchronising.
    wire active_serial = (i_scheme_select == `FCS_SCHEME_ACTIVE);
    // A reconfiguration request or a neighbour pulling status low forces a restart from configuration or initialization.
    wire restart = (~reconf_n_s) | (~status_s);
    // Our own reset-stage pull on status needs a few cycles to leave the synchroniser.
    wire status_settled = (stage_cnt_q >= `FCS_STATUS_SETTLE);

    // Next-state logic for the configuration cycle.
    always @* begin
        state_d = state_q;
        case (state_q)
            `FCS_ST_POR: begin
                if (por_cnt_q == POR_CYCLES) begin
                    state_d = `FCS_ST_WAIT;
                end
            end
            `FCS_ST_WAIT: begin
                // Enter configuration mode only when status is seen high.
                if (status_s && reconf_n_s) begin
                    state_d = `FCS_ST_RESET;
                end
            end
            `FCS_ST_RESET: begin
                // Reset stage ends after a fixed count, then configuration.
                if (stage_cnt_q == `FCS_RST_STAGE_CYCLES) begin
                    state_d = `FCS_ST_CONFIG;
                end
            end
            `FCS_ST_CONFIG: begin
                // A low status is believed only once our own pull has cleared, or the
                // stage would end at once on the echo of the reset stage.
                if ((restart && status_settled) || !reconf_n_s || i_config_error) begin
                    state_d = `FCS_ST_WAIT;
                end else if (scan_done_s || (!ce_n_s && i_config_data_done && done_s)) begin
                    // Done is wired-AND: all devices must release before init, unless a scan configuration finished.
                    state_d = `FCS_ST_INIT;
                end
            end
            `FCS_ST_INIT: begin
                if (restart) begin
                    state_d = `FCS_ST_WAIT;
                end else if (stage_cnt_q == `FCS_INIT_CYCLES) begin
                    state_d = `FCS_ST_USER;
                end
            end
            `FCS_ST_USER: begin
                if (!reconf_n_s) begin
                    state_d = `FCS_ST_WAIT;
                end
            end
            default: begin
                state_d = `FCS_ST_POR;
            end
        endcase
    end

    // State register and counters.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q <= `FCS_ST_POR;
            por_cnt_q <= {`FCS_POR_W{1'b0}};
            stage_cnt_q <= {`FCS_STAGE_W{1'b0}};
            scan_cfg_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // Power-on counter runs only during power-on reset.
            if (state_q == `FCS_ST_POR && por_cnt_q != POR_CYCLES) begin
                por_cnt_q <= por_cnt_q + 1'b1;
            end
            // Stage counter restarts on every state change.
            if (state_d != state_q) begin
                stage_cnt_q <= {`FCS_STAGE_W{1'b0}};
            end else begin
                stage_cnt_q <= stage_cnt_q + 1'b1;
            end
            // Remember a scan configuration for chain hand-off.
            if (state_q == `FCS_ST_CONFIG && scan_done_s) begin
                scan_cfg_q <= 1'b1;
            end else if (state_q == `FCS_ST_WAIT) begin
                scan_cfg_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    // All pins and indicators are driven from flip-flops.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            // Power-on: status and done pulled low, user pins tri-stated.
            o_config_status_n_out <= 1'b0;
            o_config_status_n_oe_n <= 1'b0;
            o_config_complete_flag_out <= 1'b0;
            o_config_complete_flag_oe_n <= 1'b0;
            o_chain_enable_out_n <= 1'b1;
            o_serial_command_out <= 1'b0;
            o_serial_load_enable <= 1'b0;
            o_serial_data_bit <= 1'b0;
            o_user_io_oe_n <= 1'b1;
            o_user_io_pullup_en <= 1'b1;
            o_user_mode <= 1'b0;
            o_stage_reset <= 1'b0;
            o_stage_config <= 1'b0;
            o_stage_init <= 1'b0;
        end else begin
            // Open-drain: output value is always low, only the enable moves.
            o_config_status_n_out <= 1'b0;
            o_config_complete_flag_out <= 1'b0;
            // Status pulled low in power-on, reset stage, or on error.
            o_config_status_n_oe_n <= ~(state_d == `FCS_ST_POR || state_d == `FCS_ST_RESET
                                        || (state_q == `FCS_ST_CONFIG && i_config_error));
            // Done held low until this device has its data.
            o_config_complete_flag_oe_n <= ~(state_d == `FCS_ST_POR || state_d == `FCS_ST_WAIT
                || state_d == `FCS_ST_RESET
                || (state_d == `FCS_ST_CONFIG && !i_config_data_done));
            // Chain enable passes on once this device has finished.
            o_chain_enable_out_n <= ~(state_d == `FCS_ST_INIT || state_d == `FCS_ST_USER
                                      || scan_cfg_q);
            // Active serial command path talks to the memory in configuration.
            o_serial_load_enable <= active_serial && !ce_n_s && state_d == `FCS_ST_CONFIG;
            // Command output trails the load enable by one cycle, so the memory sees the load first.
            o_serial_command_out <= active_serial && !ce_n_s && state_q == `FCS_ST_CONFIG;
            o_serial_data_bit <= mem_data_s;
            // User pins tri-stated with weak pull-ups until user mode.
            o_user_io_oe_n <= (state_d != `FCS_ST_USER);
            o_user_io_pullup_en <= (state_d != `FCS_ST_USER);
            o_user_mode <= (state_d == `FCS_ST_USER);
            o_stage_reset <= (state_d == `FCS_ST_RESET);
            o_stage_config <= (state_d == `FCS_ST_CONFIG);
            o_stage_init <= (state_d == `FCS_ST_INIT);
        end
    end

endmodule // fcs_config_sequencer

`default_nettype wire

// file: tb/fcs_checker_assertions.sv
// Concurrent checks on the ports of the configuration sequencer.
`timescale 1ns/1ps
`default_nettype none
module fcs_checker (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_config_status_n,
    input wire i_reconfig_request_n,
    input wire [1:0] i_scheme_select,
    input wire o_config_status_n_out,
    input wire o_config_status_n_oe_n,
    input wire o_config_complete_flag_out,
    input wire o_config_complete_flag_oe_n,
    input wire o_chain_enable_out_n,
    input wire o_serial_command_out,
    input wire o_user_io_oe_n,
    input wire o_user_io_pullup_en,
    input wire o_user_mode,
    input wire o_stage_reset,
    input wire o_stage_config,
    input wire o_stage_init
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Reset stage lasts nine cycles and hands over to configuration.
    sequence s_reset_run;
        o_stage_reset[*8] ##1 o_stage_config;
    endsequence
    a_por_hold_low: assert property ($fell(i_rst) |->
        !o_config_status_n_oe_n && !o_config_complete_flag_oe_n && o_user_io_oe_n)
        else $error("status, done or user pins wrong after reset");
    a_status_seen_high: assert property ($rose(o_stage_reset) |->
        $past(i_config_status_n, 3)) else $error("reset stage without status high");
    a_user_pins_float: assert property (!o_user_mode |->
        o_user_io_oe_n && o_user_io_pullup_en) else $error("user pins active early");
    a_stage_order: assert property ($rose(o_stage_reset) |=> s_reset_run)
        else $error("reset stage length or successor wrong");
    a_user_after_init: assert property ($rose(o_user_mode) |->
        $past(o_stage_init)) else $error("user mode not entered from init");
    a_cmd_window: assert property (o_serial_command_out |->
        $past(o_stage_config) && i_scheme_select == 2'h0) else $error("command out of window");
    a_chain_pass_on: assert property ($rose(o_stage_init) |->
        !o_chain_enable_out_n) else $error("chain enable not passed on");
    a_status_restart: assert property (o_stage_config && !i_config_status_n |->
        ##[1:4] !o_stage_config) else $error("status low did not stop configuration");
    a_reconfig_request: assert property (o_user_mode && !i_reconfig_request_n |->
        ##[1:4] !o_user_mode) else $error("reconfiguration request ignored");
    a_open_drain_only: assert property (!o_config_status_n_out &&
        !o_config_complete_flag_out) else $error("shared line driven high");
endmodule // fcs_checker
bind fcs_config_sequencer fcs_checker u_fcs_checker (.*);
`default_nettype wire

// file: tb/fcs_far_side.sv
// Neighbour device and serial memory on the shared configuration lines.
`timescale 1ns/1ps
`default_nettype none
module fcs_far_side (
    input wire logic i_core_clk,
    input wire logic i_hold_status,
    input wire logic i_hold_done,
    input wire logic i_status_oe_n,
    input wire logic i_done_oe_n,
    output logic o_status_wire,
    output logic o_done_wire,
    output var logic o_mem_bit = 1'b0
);
    // Pull-ups make a wired-AND: a low from any party wins.
    assign o_status_wire = i_status_oe_n & ~i_hold_status;
    assign o_done_wire = i_done_oe_n & ~i_hold_done;
    // Memory data changes every cycle so a stale sample never looks right.
    always @(posedge i_core_clk) begin
        o_mem_bit <= ~o_mem_bit;
    end
endmodule // fcs_far_side
`default_nettype wire

// file: tb/test_fpga_config_sequencer.sv
// Self-checking testbench of the configuration sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_fpga_config_sequencer;
    logic i_core_clk = 0, i_rst = 1, i_chain_enable_in_n = 0, i_reconfig_request_n = 1;
    logic i_scan_config_done = 0, i_config_data_done = 0, i_config_error = 0;
    logic [1:0] i_scheme_select = 2'h0;
    logic hold_status = 1, hold_done = 0;
    int fails = 0, checks = 0;
    wire i_config_status_n, i_config_complete_flag, i_serial_memory_data_in;
    wire o_config_status_n_out, o_config_status_n_oe_n, o_config_complete_flag_out;
    wire o_config_complete_flag_oe_n, o_chain_enable_out_n, o_serial_command_out;
    wire o_serial_load_enable, o_serial_data_bit, o_user_io_oe_n, o_user_io_pullup_en;
    wire o_user_mode, o_stage_reset, o_stage_config, o_stage_init;
    fcs_config_sequencer #(.POR_CYCLES(25'h14)) u_fcs_config_sequencer (.*);
    fcs_far_side u_fcs_far_side (
        .i_core_clk(i_core_clk),
        .i_hold_status(hold_status),
        .i_hold_done(hold_done),
        .i_status_oe_n(o_config_status_n_oe_n),
        .i_done_oe_n(o_config_complete_flag_oe_n),
        .o_status_wire(i_config_status_n),
        .o_done_wire(i_config_complete_flag),
        .o_mem_bit(i_serial_memory_data_in)
    );
    always #2.5 i_core_clk = ~i_core_clk;
    // Stage flags by index: reset, config, init, user.
    function automatic logic sig(input int k);
        case (k)
            0: sig = o_stage_reset;
            1: sig = o_stage_config;
            2: sig = o_stage_init;
            default: sig = o_user_mode;
        endcase
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // Bounded wait for a stage flag to reach a level.
    task automatic wt(input int k, input logic v);
        for (int n = 0; n < 100 && sig(k) !== v; n++) cyc(1);
    endtask
    task automatic chk(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task t_power_up;
        chk(o_config_status_n_oe_n, 0);
        chk(o_config_complete_flag_oe_n, 0);
        chk(o_user_io_oe_n, 1);
        @(posedge i_core_clk) i_rst <= 0;
        cyc(40);
        chk(o_config_status_n_oe_n, 1);
        chk(o_stage_reset, 0);
        @(posedge i_core_clk) hold_status <= 0;
        wt(0, 1);
        chk(o_stage_reset, 1);
        wt(1, 1);
        chk(o_serial_load_enable, 1);
        chk(o_serial_command_out, 0);
        cyc(1);
        chk(o_serial_command_out, 1);
        chk(o_serial_data_bit, ~i_serial_memory_data_in);
        chk(o_user_io_pullup_en, 1);
        @(posedge i_core_clk) i_config_data_done <= 1;
        hold_done <= 1;
        cyc(10);
        chk(o_stage_init, 0);
        @(posedge i_core_clk) hold_done <= 0;
        wt(2, 1);
        chk(o_chain_enable_out_n, 0);
        @(posedge i_core_clk) i_config_data_done <= 0;
        wt(3, 1);
        chk(o_user_io_oe_n, 0);
        $display("power-up test done");
    endtask
    task t_restart;
        @(posedge i_core_clk) i_reconfig_request_n <= 0;
        wt(3, 0);
        chk(o_user_io_oe_n, 1);
        @(posedge i_core_clk) i_reconfig_request_n <= 1;
        wt(1, 1);
        @(posedge i_core_clk) hold_status <= 1;
        cyc(10);
        chk(o_stage_config, 0);
        chk(o_stage_reset, 0);
        @(posedge i_core_clk) hold_status <= 0;
        wt(1, 1);
        @(posedge i_core_clk) i_config_error <= 1;
        @(posedge i_core_clk) i_config_error <= 0;
        #1;
        wt(1, 0);
        chk(o_stage_config, 0);
        $display("restart test done");
    endtask
    task t_scan;
        @(posedge i_core_clk) i_scheme_select <= 2'h1;
        wt(1, 1);
        cyc(1);
        chk(o_serial_command_out, 0);
        chk(o_serial_load_enable, 0);
        @(posedge i_core_clk) i_scan_config_done <= 1;
        wt(2, 1);
        chk(o_chain_enable_out_n, 0);
        @(posedge i_core_clk) i_scan_config_done <= 0;
        wt(3, 1);
        chk(o_user_mode, 1);
        $display("scan test done");
    endtask
    initial begin
        cyc(16);
        t_power_up;
        t_restart;
        t_scan;
        end_sim;
    end
    initial begin
        #50000;
        fails++;
        end_sim;
    end
endmodule // test_fpga_config_sequencer
`default_nettype wire
